// ===== timer_trigger_event_flags.sv
// Trigger conditioning, interrupt enables, status flags and event generation
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "timer_trig_consts.svh"
module timer_trigger_event_flags #(
    parameter int CHANS = 4
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic [7:0]                  addr,
    input  wire logic [7:0]                  wrData,
    input  wire logic                        wrStb,
    input  wire logic                        rdStb,
    output logic [7:0]                       rdData,
    input  wire logic                        triggerPin,
    input  wire timer_trig_pkg::slave_mode_t slaveModeSel,
    input  wire logic [2:0]                  triggerSourceSel,
    input  wire logic                        slaveTrigAlt,
    input  wire logic                        breakIn,
    input  wire logic                        ctrlPreloadEn,
    input  wire logic                        commutHw,
    input  wire logic [1:0]                  centerAlignSel,
    input  wire timer_trig_pkg::cnt_status_t cntStatus,
    input  wire logic                        updDisable,
    input  wire logic                        updSrcRestrict,
    input  wire logic [CHANS-1:0]            chanIsInput,
    input  wire logic [CHANS-1:0]            cmpEqual,
    input  wire logic [CHANS-1:0]            cmpAboveReload,
    input  wire logic [CHANS-1:0]            captureEvt,
    input  wire logic [CHANS-1:0]            captureLowRead,
    output logic                             filteredTrigger,
    output logic                             counterTick,
    output logic                             trigEvent,
    output logic [7:0]                       irqReq,
    output logic                             mainOutEnClr,
    output logic                             commutLoad,
    output logic [CHANS-1:0]                 captureNow,
    output logic                             updEvent,
    output logic                             cntReinit,
    output logic                             cntLoadReload,
    output logic                             prescClear
);
    import timer_trig_pkg::*;

    ext_trig_cfg_t    cfg_reg;
    logic [7:0]       irqEn_reg, status_reg, status_next;
    logic [7:0]       ovcap_reg, ovcap_next, gen_reg, rdData_reg;
    logic             sync1_reg, sync2_reg, polPrev_reg;
    logic [2:0]       preCnt_reg;
    logic [4:0]       divCnt_reg;
    logic [3:0]       filtCnt_reg;
    logic             filt_reg, filtPrev_reg, trgiPrev_reg;
    logic             tick_reg, trigEv_reg, moeClr_reg, comLoad_reg;
    logic [7:0]       irq_reg;
    logic [CHANS-1:0] capNow_reg;
    logic             upd_reg, reinit_reg, loadArr_reg, pscClr_reg;
    logic             polCorr, polRise, prescaled, sampleEn;
    logic             slave_trigger_in, trgiRise, trgiFall, filtRise, trigHit;
    logic             comXfer, swUpd, anyReinit;
    logic [CHANS-1:0] chanGen, capHit, cmpHit;
    logic [7:0]       set1, clr1, set2, clr2;
    filt_param_t      fp;

    // Sample rate mask and event count for each filter code
    function automatic filt_param_t filt_param(input logic [3:0] code);
        filt_param_t p;
        p = '{mask: 5'h00, len: 4'h1};
        unique case (code)
            4'h0: p = '{mask: 5'h00, len: 4'h1};
            4'h1: p = '{mask: 5'h00, len: 4'h2};
            4'h2: p = '{mask: 5'h00, len: 4'h4};
            4'h3: p = '{mask: 5'h00, len: 4'h8};
            4'h4: p = '{mask: 5'h01, len: 4'h6};
            4'h5: p = '{mask: 5'h01, len: 4'h8};
            4'h6: p = '{mask: 5'h03, len: 4'h6};
            4'h7: p = '{mask: 5'h03, len: 4'h8};
            4'h8: p = '{mask: 5'h07, len: 4'h6};
            4'h9: p = '{mask: 5'h07, len: 4'h8};
            4'ha: p = '{mask: 5'h0f, len: 4'h5};
            4'hb: p = '{mask: 5'h0f, len: 4'h6};
            4'hc: p = '{mask: 5'h0f, len: 4'h8};
            4'hd: p = '{mask: 5'h1f, len: 4'h5};
            4'he: p = '{mask: 5'h1f, len: 4'h6};
            4'hf: p = '{mask: 5'h1f, len: 4'h8};
        endcase
        return p;
    endfunction

    // Bits written as zero to a clear-on-zero register
    function automatic logic [7:0] zero_clear(input logic hit,
                                              input logic [7:0] d);
        return hit ? ~d : 8'h00;
    endfunction

    // Pin synchroniser; only the second stage feeds logic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= triggerPin;
            sync2_reg <= sync1_reg;
        end
    end

    assign polCorr = sync2_reg ^ cfg_reg.trigPolarity;
    assign polRise = polCorr & ~polPrev_reg;

    // Edge counter of the prescaler; its bits are divided copies
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            polPrev_reg <= 1'b0;
            preCnt_reg  <= 3'h0;
        end else begin
            polPrev_reg <= polCorr;
            if (polRise)
                preCnt_reg <= preCnt_reg + 3'h1;
        end
    end

    // Division by 2^sel; the pin rate limit is the source's job
    always_comb begin
        unique case (cfg_reg.trigPrescaleSel)
            2'h0: prescaled = polCorr;
            2'h1: prescaled = preCnt_reg[0];
            2'h2: prescaled = preCnt_reg[1];
            2'h3: prescaled = preCnt_reg[2];
        endcase
    end

    assign fp       = filt_param(cfg_reg.trigFilterSel);
    assign sampleEn = ((divCnt_reg & fp.mask) == fp.mask);

    // Free running divider gives the sampling enable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            divCnt_reg <= 5'h00;
        else
            divCnt_reg <= divCnt_reg + 5'h01;
    end

    // Run of differing samples; any agreeing sample restarts it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            filtCnt_reg <= 4'h0;
            filt_reg    <= 1'b0;
        end else if (sampleEn) begin
            if (prescaled == filt_reg) begin
                filtCnt_reg <= 4'h0;
            end else if (filtCnt_reg + 4'h1 >= fp.len) begin
                filt_reg    <= prescaled;
                filtCnt_reg <= 4'h0;
            end else begin
                filtCnt_reg <= filtCnt_reg + 4'h1;
            end
        end
    end

    assign slave_trigger_in     = (triggerSourceSel == `TS_FILTERED) ? filt_reg : slaveTrigAlt;
    assign trgiRise = slave_trigger_in & ~trgiPrev_reg;
    assign trgiFall = ~slave_trigger_in & trgiPrev_reg;
    assign filtRise = filt_reg & ~filtPrev_reg;

    // Trigger event; gated mode counts both edges
    always_comb begin
        unique case (slaveModeSel)
            SM_GATED:                   trigHit = trgiRise | trgiFall;
            SM_RESET, SM_TRIG, SM_EXTCK: trigHit = trgiRise;
            default:                    trigHit = 1'b0;
        endcase
    end

    // Event and edge pipelines; mode 2 wins over mode 1 as clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            filtPrev_reg <= 1'b0;
            trgiPrev_reg <= 1'b0;
            tick_reg     <= 1'b0;
            trigEv_reg   <= 1'b0;
        end else begin
            filtPrev_reg <= filt_reg;
            trgiPrev_reg <= slave_trigger_in;
            trigEv_reg   <= trigHit;
            if (cfg_reg.extClk2Enable)
                tick_reg <= filtRise;
            else
                tick_reg <= (slaveModeSel == SM_EXTCK) & trgiRise;
        end
    end

    // Event generation pulses last exactly one cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            gen_reg <= 8'h00;
        else if (wrStb && addr == `ADDR_EVT_GEN)
            gen_reg <= wrData;
        else
            gen_reg <= 8'h00;
    end

    assign chanGen   = gen_reg[`BIT_CHAN_HI:`BIT_CHAN_LO];
    assign swUpd     = gen_reg[`BIT_UPD];
    assign comXfer   = (gen_reg[`BIT_COMMUT] & ctrlPreloadEn) | commutHw;
    assign anyReinit = swUpd | cntStatus.trigReinit;
    assign capHit    = chanIsInput & (captureEvt | chanGen);

    // Compare hits by center-aligned direction, or at wrap when above reload
    always_comb begin
        for (int i = 0; i < CHANS; i++) begin
            if (cmpAboveReload[i])
                cmpHit[i] = cntStatus.countingDown ? cntStatus.underflow
                                                   : cntStatus.overflow;
            else if (centerAlignSel == `CMS_DOWN_ONLY)
                cmpHit[i] = cmpEqual[i] & cntStatus.countingDown;
            else if (centerAlignSel == `CMS_UP_ONLY)
                cmpHit[i] = cmpEqual[i] & ~cntStatus.countingDown;
            else
                cmpHit[i] = cmpEqual[i];
        end
    end

    // Flag sets and clears; a set in the clear cycle is kept
    always_comb begin
        set1 = 8'h00;
        set1[`BIT_BRK]    = breakIn | gen_reg[`BIT_BRK];
        set1[`BIT_TRIG]   = trigHit | gen_reg[`BIT_TRIG];
        set1[`BIT_COMMUT] = comXfer;
        set1[`BIT_CHAN_HI:`BIT_CHAN_LO] =
            (chanIsInput & (captureEvt | chanGen)) |
            (~chanIsInput & (cmpHit | chanGen));
        set1[`BIT_UPD] = ~updDisable & ((cntStatus.overflow | cntStatus.underflow) |
                         (~updSrcRestrict & anyReinit));
        clr1 = zero_clear(wrStb && addr == `ADDR_EVT_STATUS, wrData);
        if (breakIn)
            clr1[`BIT_BRK] = 1'b0;
        clr1[`BIT_CHAN_HI:`BIT_CHAN_LO] = clr1[`BIT_CHAN_HI:`BIT_CHAN_LO] |
                                          (captureLowRead & chanIsInput);
        status_next = (status_reg & ~clr1) | set1;
        set2 = 8'h00;
        set2[`BIT_CHAN_HI:`BIT_CHAN_LO] =
            capHit & status_reg[`BIT_CHAN_HI:`BIT_CHAN_LO];
        clr2 = zero_clear(wrStb && addr == `ADDR_OVCAP_STATUS, wrData);
        ovcap_next = ((ovcap_reg & ~clr2) | set2) & `OVCAP_MASK;
    end

    // Software held registers and flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_reg    <= `EXT_TRIG_RESET;
            irqEn_reg  <= `IRQ_EN_RESET;
            status_reg <= `EVT_STATUS_RESET;
            ovcap_reg  <= `OVCAP_RESET;
        end else begin
            status_reg <= status_next;
            ovcap_reg  <= ovcap_next;
            if (wrStb && addr == `ADDR_EXT_TRIG_CFG)
                cfg_reg <= wrData;
            if (wrStb && addr == `ADDR_IRQ_EN)
                irqEn_reg <= wrData;
        end
    end

    // Read data stand one cycle after the strobe; event bits read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData_reg <= 8'h00;
        end else if (rdStb) begin
            unique case (addr)
                `ADDR_EXT_TRIG_CFG: rdData_reg <= cfg_reg;
                `ADDR_IRQ_EN:       rdData_reg <= irqEn_reg;
                `ADDR_EVT_STATUS:   rdData_reg <= status_reg;
                `ADDR_OVCAP_STATUS: rdData_reg <= ovcap_reg;
                default:            rdData_reg <= 8'h00;
            endcase
        end else begin
            rdData_reg <= 8'h00;
        end
    end

    // Requests follow flags one cycle behind; the flag is the cause
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            irq_reg <= 8'h00;
        else
            irq_reg <= status_reg & irqEn_reg;
    end

    // Strobes to the counter core, channels and output stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            moeClr_reg  <= 1'b0;
            comLoad_reg <= 1'b0;
            capNow_reg  <= '0;
            upd_reg     <= 1'b0;
            reinit_reg  <= 1'b0;
            loadArr_reg <= 1'b0;
            pscClr_reg  <= 1'b0;
        end else begin
            moeClr_reg  <= gen_reg[`BIT_BRK];
            comLoad_reg <= comXfer;
            capNow_reg  <= chanGen & chanIsInput;
            upd_reg     <= ~updDisable & (cntStatus.overflow |
                           cntStatus.underflow | anyReinit);
            reinit_reg  <= anyReinit;
            pscClr_reg  <= swUpd;
            loadArr_reg <= swUpd & cntStatus.countingDown &
                           (centerAlignSel == `CMS_EDGE);
        end
    end

    assign rdData          = rdData_reg;
    assign filteredTrigger = filt_reg;
    assign counterTick     = tick_reg;
    assign trigEvent       = trigEv_reg;
    assign irqReq          = irq_reg;
    assign mainOutEnClr    = moeClr_reg;
    assign commutLoad      = comLoad_reg;
    assign captureNow      = capNow_reg;
    assign updEvent        = upd_reg;
    assign cntReinit       = reinit_reg;
    assign cntLoadReload   = loadArr_reg;
    assign prescClear      = pscClr_reg;

    // Checks beside the logic
    sequence swBreakWr;
        wrStb && addr == `ADDR_EVT_GEN && wrData[`BIT_BRK];
    endsequence
    sequence swTrigWr;
        wrStb && addr == `ADDR_EVT_GEN && wrData[`BIT_TRIG];
    endsequence

    soft_break_a: assert property (@(posedge clk_sys) disable iff (rst)
        swBreakWr |-> ##1 status_next[`BIT_BRK] ##1 mainOutEnClr && status_reg[`BIT_BRK])
        else $error("software break did not clear enable and set flag");
    soft_trig_a: assert property (@(posedge clk_sys) disable iff (rst)
        swTrigWr |-> ##2 status_reg[`BIT_TRIG])
        else $error("software trigger did not set trigger flag");
    gen_self_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (gen_reg != 8'h00) |=> (gen_reg == 8'h00) || $past(wrStb))
        else $error("event bit did not return to zero");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        irqReq == ($past(status_reg) & $past(irqEn_reg)))
        else $error("interrupt request not flag and enable");
    brk_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        breakIn |=> status_reg[`BIT_BRK])
        else $error("break flag lost while break active");
    one_keeps_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrStb && addr == `ADDR_EVT_STATUS && wrData[`BIT_UPD] && status_reg[`BIT_UPD]
        |=> status_reg[`BIT_UPD])
        else $error("writing one cleared a flag");
    upd_restrict_a: assert property (@(posedge clk_sys) disable iff (rst)
        updSrcRestrict && !cntStatus.overflow && !cntStatus.underflow &&
        !status_reg[`BIT_UPD] && !(wrStb && addr == `ADDR_EVT_STATUS)
        |=> !status_reg[`BIT_UPD])
        else $error("update flag set by excluded source");
    clk2_pick_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_reg.extClk2Enable && $stable(cfg_reg) |=> counterTick == $past(filtRise))
        else $error("clock mode 2 did not use filtered trigger");
    filt_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(filt_reg) && $stable(cfg_reg) |-> $past(filtCnt_reg) + 4'h1 >= fp.len)
        else $error("filter changed before count reached");
    overcap_a: assert property (@(posedge clk_sys) disable iff (rst)
        capHit[0] && status_reg[`BIT_CHAN_LO] |=> ovcap_reg[`BIT_CHAN_LO])
        else $error("overcapture not flagged");
    commut_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        gen_reg[`BIT_COMMUT] && !ctrlPreloadEn && !commutHw |=> !commutLoad)
        else $error("commutation load without preload control");
    upd_sw_a: assert property (@(posedge clk_sys) disable iff (rst)
        gen_reg[`BIT_UPD] && !updDisable && !updSrcRestrict |=> status_reg[`BIT_UPD])
        else $error("software update did not set update flag");
    psc_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        gen_reg[`BIT_UPD] |=> prescClear && cntReinit)
        else $error("software update did not clear prescaler");
endmodule

// ===== timer_trig_consts.svh
// Register offsets, field positions and reset values of the trigger/event block
// How it works
// - Polarity bit inverts trigger pin when set
// - Clock mode 2 counts filtered trigger edges
// - Mode 2 overrides; filtered trigger is clock
// - Prescaler divides by 1, 2, 4 or 8
// - Filter code picks sample rate and count
// - Interrupt request needs flag and enable
// - Break flag clears only while break inactive
// - Trigger flag on active edge, gated both
// - Commutation flag set on control transfer
// - Compare flag on match, direction qualified
// - Capture flag on capture, cleared by read
// - Update flag on overflow or allowed updates
// - Flags clear on zero write, one keeps
// - Overcapture when capture hits set flag
// - Event bits self clear, write only
// - Software break clears output enable, flags
// - Software trigger sets trigger flag
// - Software commutation loads preloaded control bits
// - Software channel event sets flag, captures on input channels
// - Software update reinitialises counter and shadows
// - Restrict bit limits update flag to wraps
`ifndef TIMER_TRIG_CONSTS_SVH
`define TIMER_TRIG_CONSTS_SVH
`define ADDR_EXT_TRIG_CFG 8'h03
`define ADDR_IRQ_EN       8'h04
`define ADDR_EVT_STATUS   8'h05
`define ADDR_OVCAP_STATUS 8'h06
`define ADDR_EVT_GEN      8'h07
`define EXT_TRIG_RESET    8'h00
`define IRQ_EN_RESET      8'h00
`define EVT_STATUS_RESET  8'h00
`define OVCAP_RESET       8'h00
`define OVCAP_MASK        8'h1e
`define BIT_BRK           7
`define BIT_TRIG          6
`define BIT_COMMUT        5
`define BIT_CHAN_HI       4
`define BIT_CHAN_LO       1
`define BIT_UPD           0
`define TS_FILTERED       3'h7
`define CMS_EDGE          2'h0
`define CMS_DOWN_ONLY     2'h1
`define CMS_UP_ONLY       2'h2
`endif

// ===== timer_trig_pkg.sv
// Types shared by the trigger/event block
package timer_trig_pkg;
    typedef struct packed {
        logic       trigPolarity;
        logic       extClk2Enable;
        logic [1:0] trigPrescaleSel;
        logic [3:0] trigFilterSel;
    } ext_trig_cfg_t;
    typedef struct packed {
        logic       overflow;
        logic       underflow;
        logic       countingDown;
        logic       trigReinit;
    } cnt_status_t;
    typedef struct packed {
        logic [4:0] mask;
        logic [3:0] len;
    } filt_param_t;
    typedef enum logic [2:0] {
        SM_OFF   = 3'b000, SM_ENC1  = 3'b001, SM_ENC2  = 3'b010,
        SM_ENC3  = 3'b011, SM_RESET = 3'b100, SM_GATED = 3'b101,
        SM_TRIG  = 3'b110, SM_EXTCK = 3'b111
    } slave_mode_t;
endpackage

// ===== trig_pin_source.sv
// Model of the external trigger source that drives the timer's trigger pin
`timescale 1ns/10ps
module trig_pin_source (
    input  wire logic clk_sys,
    output logic      pin
);
    // Pin rests low between pulse trains
    initial pin = 1'b0;

    // Callers keep hi plus lo at 4 or more so the rate stays at a quarter clock at most
    task automatic pulses(input int n, input int hi, input int lo);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge clk_sys);
            pin <= 1'b1;
            repeat (hi) @(posedge clk_sys);
            pin <= 1'b0;
            repeat (lo - 1) @(posedge clk_sys);
        end
    endtask
endmodule

// ===== timer_trigger_event_flags_tb_top.sv
// Self-checking bench for the trigger conditioning and event flag block
`timescale 1ns/10ps
`include "timer_trig_consts.svh"
module timer_trigger_event_flags_tb_top;
    import timer_trig_pkg::*;
    logic        clk_sys, rst, wrStb, rdStb, triggerPin, slaveTrigAlt, breakIn;
    logic        ctrlPreloadEn, commutHw, updDisable, updSrcRestrict, filteredTrigger;
    logic        counterTick, trigEvent, mainOutEnClr, commutLoad, updEvent, cntReinit;
    logic        cntLoadReload, prescClear;
    logic [7:0]  addr, wrData, rdData, irqReq, v;
    logic [2:0]  triggerSourceSel;
    logic [1:0]  centerAlignSel;
    logic [3:0]  chanIsInput, cmpEqual, cmpAboveReload, captureEvt, captureLowRead, captureNow;
    slave_mode_t slaveModeSel;
    cnt_status_t cntStatus;
    int          n_errors = 0, n_checks = 0, seed = 32'h1660, mSr = 0, mOv = 0, mIen = 0;
    int          cMoe = 0, cCom = 0, cUpd = 0, cCap = 0, cLoad = 0, cTick = 0, b, s, t0;
    int          cTrig = 0, cReinit = 0, cPsc = 0;

    timer_trigger_event_flags #(.CHANS(4)) u_timer_trigger_event_flags (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .triggerPin(triggerPin), .slaveModeSel(slaveModeSel),
        .triggerSourceSel(triggerSourceSel), .slaveTrigAlt(slaveTrigAlt), .breakIn(breakIn),
        .ctrlPreloadEn(ctrlPreloadEn), .commutHw(commutHw), .centerAlignSel(centerAlignSel),
        .cntStatus(cntStatus), .updDisable(updDisable), .updSrcRestrict(updSrcRestrict),
        .chanIsInput(chanIsInput), .cmpEqual(cmpEqual), .cmpAboveReload(cmpAboveReload),
        .captureEvt(captureEvt), .captureLowRead(captureLowRead),
        .filteredTrigger(filteredTrigger), .counterTick(counterTick), .trigEvent(trigEvent),
        .irqReq(irqReq), .mainOutEnClr(mainOutEnClr), .commutLoad(commutLoad),
        .captureNow(captureNow), .updEvent(updEvent), .cntReinit(cntReinit),
        .cntLoadReload(cntLoadReload), .prescClear(prescClear));

    trig_pin_source u_trig_pin_source (.clk_sys(clk_sys), .pin(triggerPin));

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Pulse counters for the outputs that only ever pulse; mid-cycle, where they are settled
    always @(negedge clk_sys) begin
        if (!rst) begin
            cTrig   += trigEvent;
            cReinit += cntReinit;
            cPsc    += prescClear;
            cMoe  += mainOutEnClr;
            cCom  += commutLoad;
            cUpd  += updEvent;
            cCap  += $countones(captureNow);
            cLoad += cntLoadReload;
            cTick += counterTick;
        end
    end

    task automatic close_out();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk_sys);
        wrStb  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk_sys);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask

    // Requests and both status registers against the model; ends on a rising edge
    task automatic cmpSr();
        repeat (4) @(posedge clk_sys);
        #1 chk(irqReq, 8'(mSr & mIen));
        rd(`ADDR_EVT_STATUS, v);
        chk(v, 8'(mSr));
        rd(`ADDR_OVCAP_STATUS, v);
        chk(v, 8'(mOv));
        @(posedge clk_sys);
    endtask

    task automatic pinRun(input logic [7:0] cfg, input int n, input int hi, input int lo,
                          input int exp);
        wr(`ADDR_EXT_TRIG_CFG, cfg);
        repeat (12) @(posedge clk_sys);
        t0 = cTick;
        u_trig_pin_source.pulses(n, hi, lo);
        repeat (24) @(posedge clk_sys);
        chk(8'(cTick - t0), 8'(exp));
    endtask

    // Bound on the whole run
    initial begin
        #400000;
        n_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        {addr, wrData, wrStb, rdStb, slaveTrigAlt, breakIn, commutHw} = '0;
        {updDisable, updSrcRestrict, cmpEqual, cmpAboveReload, captureEvt} = '0;
        {captureLowRead, triggerSourceSel, centerAlignSel, cntStatus} = '0;
        slaveModeSel = SM_OFF;
        ctrlPreloadEn = 1'b1;
        chanIsInput = 4'b0011;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (b = 2; b < 9; b++) begin
            rd(8'(b), v);
            chk(v, 8'h00);
        end
        for (b = 3; b < 5; b++) begin
            s = $random(seed);
            wr(8'(b), 8'(s));
            rd(8'(b), v);
            chk(v, 8'(s));
        end
        mIen = 8'hff;
        wr(`ADDR_IRQ_EN, 8'hff);
        // Each generation bit on its own, then cleared by a zero write
        for (b = 0; b < 8; b++) begin
            wr(`ADDR_EVT_GEN, 8'(1 << b));
            mSr = 1 << b;
            cmpSr();
            rd(`ADDR_EVT_GEN, v);
            chk(v, 8'h00);
            wr(`ADDR_EVT_STATUS, 8'(~(1 << b)));
            mSr = 0;
            cmpSr();
        end
        // Software commutation is ignored without preload control
        ctrlPreloadEn <= 1'b0;
        wr(`ADDR_EVT_GEN, 8'h20);
        cmpSr();
        ctrlPreloadEn <= 1'b1;
        chk(8'(cMoe), 8'h01);
        chk(8'(cCom), 8'h01);
        chk(8'(cUpd), 8'h01);
        chk(8'(cCap), 8'h02);
        // Second capture while the flag stands, then a low-byte read clears it
        for (s = 0; s < 2; s++) begin
            @(posedge clk_sys);
            captureEvt <= 4'h1;
            @(posedge clk_sys);
            captureEvt <= 4'h0;
        end
        mSr = 2;
        mOv = 2;
        cmpSr();
        captureLowRead <= 4'h1;
        @(posedge clk_sys);
        captureLowRead <= 4'h0;
        mSr = 0;
        wr(`ADDR_OVCAP_STATUS, 8'hff);
        cmpSr();
        wr(`ADDR_OVCAP_STATUS, 8'h00);
        mOv = 0;
        cmpSr();
        // Break flag clear refused while the break input stays active
        breakIn <= 1'b1;
        mSr = 8'h80;
        wr(`ADDR_EVT_STATUS, 8'h00);
        cmpSr();
        breakIn <= 1'b0;
        wr(`ADDR_EVT_STATUS, 8'h00);
        mSr = 0;
        cmpSr();
        // Restricted source: software update leaves the flag, a wrap sets it
        updSrcRestrict <= 1'b1;
        cntStatus.countingDown <= 1'b1;
        wr(`ADDR_EVT_GEN, 8'h01);
        cmpSr();
        chk(8'(cLoad), 8'h01);
        cntStatus.overflow <= 1'b1;
        @(posedge clk_sys);
        cntStatus.overflow <= 1'b0;
        updSrcRestrict <= 1'b0;
        mSr = 1;
        cmpSr();
        wr(`ADDR_EVT_STATUS, 8'h00);
        updDisable <= 1'b1;
        cntStatus.underflow <= 1'b1;
        @(posedge clk_sys);
        cntStatus.underflow <= 1'b0;
        mSr = 0;
        cmpSr();
        updDisable <= 1'b0;
        cntStatus.trigReinit <= 1'b1;
        @(posedge clk_sys);
        cntStatus.trigReinit <= 1'b0;
        cmpEqual <= 4'h4;
        commutHw <= 1'b1;
        @(posedge clk_sys);
        cmpEqual <= 4'h0;
        commutHw <= 1'b0;
        mSr = 8'h29;
        cmpSr();
        wr(`ADDR_EVT_STATUS, 8'h00);
        // Gated mode: both edges of the trigger input raise the flag
        slaveModeSel <= SM_GATED;
        slaveTrigAlt <= 1'b1;
        mSr = 8'h40;
        cmpSr();
        wr(`ADDR_EVT_STATUS, 8'h00);
        slaveTrigAlt <= 1'b0;
        cmpSr();
        slaveModeSel <= SM_OFF;
        // Up-only centre mode drops a down-count match; above reload hits at the wrap
        centerAlignSel <= `CMS_UP_ONLY;
        cmpAboveReload <= 4'h8;
        cmpEqual <= 4'h4;
        @(posedge clk_sys);
        cmpEqual <= 4'h0;
        cntStatus.underflow <= 1'b1;
        @(posedge clk_sys);
        cntStatus.underflow <= 1'b0;
        mSr = 8'h51;
        cmpSr();
        // Trigger pin path: polarity, prescaler, filter, clock mode routing
        wr(`ADDR_EXT_TRIG_CFG, 8'h80);
        repeat (12) @(posedge clk_sys);
        chk(8'(filteredTrigger), 8'h01);
        for (s = 0; s < 4; s++) begin
            pinRun(8'(8'h40 | (s << 4)), 16, 4, 4, 16 >> s);
        end
        pinRun(8'h43, 4, 5, 10, 0);
        pinRun(8'h43, 4, 12, 12, 4);
        slaveModeSel <= SM_EXTCK;
        triggerSourceSel <= `TS_FILTERED;
        pinRun(8'h00, 8, 4, 4, 8);
        chk(8'(cUpd), 8'h05);
        chk(8'(cReinit), 8'h03);
        chk(8'(cPsc), 8'h02);
        chk(8'(cTrig), 8'h0a);
        close_out();
    end
endmodule
